// [rtl/csio_cfg.svh]
// Offsets, field positions, reset values and timing counts of the serial shifter
`ifndef CSIO_CFG_SVH
`define CSIO_CFG_SVH

`define CSIO_AW 12
`define CSIO_A_MODE 12'hFE0
`define CSIO_A_DATA 12'hFE4
`define CSIO_A_BUSCTL 12'hFE8
`define CSIO_A_STAT 12'hFEC
`define CSIO_A_MASK 12'hFF0
`define CSIO_A_BSET 12'hFF4
`define CSIO_A_BCLR 12'hFF8
`define CSIO_A_SVA 12'hFFC

`define CSIO_B_EN 7
`define CSIO_B_MATCH 6
`define CSIO_B_WAKE 5
`define CSIO_B_MHI 4
`define CSIO_B_MMID 3
`define CSIO_B_FIRST 2
`define CSIO_B_CMD 0
`define CSIO_B_REL 1
`define CSIO_B_DONE 0
`define CSIO_BITOPS_MASK 8'hE0

`define CSIO_MODE_RST 8'h00
`define CSIO_SVA_RST 8'h00
`define CSIO_LATCH_RST 1'b1

`define CSIO_SYS_DIV16 5'h10
`define CSIO_SYS_DIV8 5'h08
`define CSIO_BITS 4'h8
`define CSIO_RESP_OK 2'h0
`define CSIO_RESP_ERR 2'h2

`endif

// [rtl/csio_pkg.sv]
// Types shared by the serial shifter modules
`default_nettype none
package csio_pkg;
  typedef enum logic [1:0] {CSIO_CLK_EXT, CSIO_CLK_TMR, CSIO_CLK_D16, CSIO_CLK_D8} csio_clk_e;
  typedef enum logic {CSIO_CG_IDLE, CSIO_CG_RUN} csio_cg_e;
  typedef struct packed {
    logic en;
    logic match;
    logic wake;
    logic [2:0] op;
    logic [1:0] clk_sel;
  } csio_mode_s;
  typedef struct packed {
    logic busy;
    logic done;
    logic latch;
    logic [7:0] data;
  } csio_shift_s;
endpackage
`default_nettype wire

// [rtl/csio_shift_core.sv]
// Eight-bit shift engine with bit counter and serial output latch
`default_nettype none
`include "csio_cfg.svh"
module csio_shift_core
  import csio_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic sck_level,
  input wire logic sin,
  input wire logic load,
  input wire logic [7:0] load_data,
  input wire logic set_latch,
  input wire logic clr_latch,
  output csio_shift_s stat
);
  logic [7:0] sr_ff;
  logic [3:0] cnt_ff;
  logic busy_ff;
  logic done_ff;
  logic latch_ff;
  logic sck_prev_ff;
  logic fall;
  logic rise;

  assign fall = sck_prev_ff & ~sck_level;
  assign rise = ~sck_prev_ff & sck_level;
  assign stat = '{busy: busy_ff, done: done_ff, latch: latch_ff, data: sr_ff};

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sck_prev_ff <= 1'b1;
    end else begin
      sck_prev_ff <= sck_level;
    end
  end

  // shift edges
  // Direction never changes; bit order is fixed up at the bus side
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sr_ff <= 8'h00;
    end else if (load) begin
      sr_ff <= load_data;
    end else if (busy_ff && enable && rise) begin
      sr_ff <= {sr_ff[6:0], sin};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      cnt_ff <= 4'h0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (!enable) begin
        busy_ff <= 1'b0;
        cnt_ff <= 4'h0;
      end else if (load) begin
        busy_ff <= 1'b1;
        cnt_ff <= 4'h0;
      end else if (busy_ff && rise) begin
        cnt_ff <= cnt_ff + 4'h1;
        if (cnt_ff == `CSIO_BITS - 4'h1) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      latch_ff <= `CSIO_LATCH_RST;
    end else if (set_latch) begin
      latch_ff <= 1'b1;
    end else if (clr_latch) begin
      latch_ff <= 1'b0;
    end else if (busy_ff && enable && fall) begin
      latch_ff <= sr_ff[7];
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_done_after_eight: assert property (done_ff |-> $past(cnt_ff) == 4'h7 && !busy_ff)
    else $error("done without eighth bit");
  a_idle_disabled: assert property (!enable |=> !busy_ff && !done_ff)
    else $error("engine active while disabled");
  a_out_on_fall: assert property (busy_ff && enable && fall && !set_latch && !clr_latch
    |=> latch_ff == $past(sr_ff[7]))
    else $error("latch not loaded on falling edge");
endmodule
`default_nettype wire

// [rtl/csio_top.sv]
// Clocked serial shifter with AXI4-Lite registers, clock generation and pins
`default_nettype none
`include "csio_cfg.svh"
module csio_top
  import csio_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [`CSIO_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`CSIO_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  input wire logic timer_out_in,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  output logic serial_out_latch,
  input wire logic serial_in_pin,
  input wire logic bus_data_pin_a_in,
  output logic bus_data_pin_a_out,
  output logic bus_data_pin_a_oe,
  input wire logic bus_data_pin_b_in,
  output logic bus_data_pin_b_out,
  output logic bus_data_pin_b_oe
);
  csio_mode_s serial_mode_reg_ff;
  csio_shift_s core;
  csio_clk_e clk_e;
  csio_cg_e cg_ff;
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  logic sck_ext;
  logic tmr_lvl;
  logic si_lvl;
  logic sba_lvl;
  logic sbb_lvl;
  logic [7:0] sva_ff;
  logic transfer_done_flag_ff;
  logic mask_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic wr_fire;
  logic rd_fire;
  logic wr_hit;
  logic [7:0] wbyte;
  logic [7:0] wr_order;
  logic [7:0] rd_order;
  logic lsb_first;
  logic two_wire;
  logic internal_clk;
  logic start_ok;
  logic load;
  logic set_latch;
  logic clr_latch;
  logic addr_match;
  logic done_ev;
  logic stat_rd;
  logic sck_level;
  logic sin;
  logic [4:0] div_cnt_ff;
  logic [4:0] div_half;
  logic sck_int_ff;
  logic sck_out_ff;
  logic sck_oe_ff;
  logic so_ff;
  logic sba_oe_ff;
  logic sbb_oe_ff;
  logic irq_ff;
  logic [31:0] nxt_rdata;
  logic nxt_rerr;

  // Pins and timer output come from outside this clock
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync1_ff <= 5'h1F;
      sync2_ff <= 5'h1F;
    end else begin
      sync1_ff <= {serial_clock_pin_in, timer_out_in, serial_in_pin,
                   bus_data_pin_a_in, bus_data_pin_b_in};
      sync2_ff <= sync1_ff;
    end
  end
  assign {sck_ext, tmr_lvl, si_lvl, sba_lvl, sbb_lvl} = sync2_ff;

  assign clk_e = csio_clk_e'(serial_mode_reg_ff.clk_sel);
  assign internal_clk = (clk_e != CSIO_CLK_EXT);
  // order select
  // Two-line mode always runs MSB first, whatever bit 2 holds
  assign lsb_first = serial_mode_reg_ff.op[0] & ~serial_mode_reg_ff.op[1];
  assign two_wire = serial_mode_reg_ff.op[1] & serial_mode_reg_ff.op[0];
  assign addr_match = (core.data == sva_ff);
  assign wbyte = s_axi_wdata[7:0];

  for (genvar i = 0; i < 8; i++) begin : g_rev
    assign wr_order[i] = lsb_first ? wbyte[7-i] : wbyte[i];
    assign rd_order[i] = lsb_first ? core.data[7-i] : core.data[i];
  end

  // AXI4-Lite write: both channels taken together, one cycle after both valid
  assign wr_fire = s_axi_awvalid & awready_ff & s_axi_wvalid & wready_ff;
  assign wr_hit = wr_fire & s_axi_wstrb[0];
  assign rd_fire = s_axi_arvalid & arready_ff;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `CSIO_RESP_OK;
    end else begin
      awready_ff <= s_axi_awvalid & s_axi_wvalid & ~awready_ff & ~bvalid_ff;
      wready_ff <= s_axi_awvalid & s_axi_wvalid & ~awready_ff & ~bvalid_ff;
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        case (s_axi_awaddr)
          `CSIO_A_MODE, `CSIO_A_DATA, `CSIO_A_BUSCTL, `CSIO_A_STAT,
          `CSIO_A_MASK, `CSIO_A_BSET, `CSIO_A_BCLR, `CSIO_A_SVA: begin
            bresp_ff <= `CSIO_RESP_OK;
          end
          default: begin
            bresp_ff <= `CSIO_RESP_ERR;
          end
        endcase
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // 84H halts
  // The match bit is never stored: it always shows the live comparison
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      serial_mode_reg_ff <= `CSIO_MODE_RST;
    end else if (wr_hit && s_axi_awaddr == `CSIO_A_MODE) begin
      serial_mode_reg_ff <= wbyte & ~(8'h01 << `CSIO_B_MATCH);
    end else if (wr_hit && s_axi_awaddr == `CSIO_A_BSET) begin
      serial_mode_reg_ff <= serial_mode_reg_ff
                          | (wbyte & `CSIO_BITOPS_MASK & ~(8'h01 << `CSIO_B_MATCH));
    end else if (wr_hit && s_axi_awaddr == `CSIO_A_BCLR) begin
      serial_mode_reg_ff <= serial_mode_reg_ff & ~(wbyte & `CSIO_BITOPS_MASK);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sva_ff <= `CSIO_SVA_RST;
      mask_ff <= 1'b0;
    end else if (wr_hit && s_axi_awaddr == `CSIO_A_SVA) begin
      sva_ff <= wbyte;
    end else if (wr_hit && s_axi_awaddr == `CSIO_A_MASK) begin
      mask_ff <= wbyte[`CSIO_B_DONE];
    end
  end

  // internal clock masked after eight bits until this start
  assign start_ok = serial_mode_reg_ff.en & (internal_clk ? ~core.busy : sck_ext);
  assign load = wr_hit & (s_axi_awaddr == `CSIO_A_DATA) & start_ok;

  // trigger bits
  // Triggers have no storage, so they read back as zero
  assign set_latch = wr_hit & (s_axi_awaddr == `CSIO_A_BUSCTL) & wbyte[`CSIO_B_REL];
  assign clr_latch = wr_hit & (s_axi_awaddr == `CSIO_A_BUSCTL) & wbyte[`CSIO_B_CMD];

  always_comb begin
    case (clk_e)
      CSIO_CLK_EXT: sck_level = sck_ext;
      CSIO_CLK_TMR: sck_level = core.busy ? tmr_lvl : 1'b1;
      default: sck_level = sck_int_ff;
    endcase
  end
  assign div_half = (clk_e == CSIO_CLK_D8) ? (`CSIO_SYS_DIV8 >> 1) : (`CSIO_SYS_DIV16 >> 1);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cg_ff <= CSIO_CG_IDLE;
      div_cnt_ff <= 5'h00;
      sck_int_ff <= 1'b1;
    end else begin
      case (cg_ff)
        CSIO_CG_IDLE: begin
          div_cnt_ff <= 5'h00;
          sck_int_ff <= 1'b1;
          if (load && clk_e[1]) begin
            cg_ff <= CSIO_CG_RUN;
          end
        end
        CSIO_CG_RUN: begin
          if (!core.busy && !load) begin
            cg_ff <= CSIO_CG_IDLE;
            sck_int_ff <= 1'b1;
          end else if (div_cnt_ff == div_half - 5'h01) begin
            div_cnt_ff <= 5'h00;
            sck_int_ff <= ~sck_int_ff;
          end else begin
            div_cnt_ff <= div_cnt_ff + 5'h01;
          end
        end
        default: begin
          cg_ff <= CSIO_CG_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    if (!two_wire) begin
      sin = si_lvl;
    end else if (serial_mode_reg_ff.op[2]) begin
      sin = sbb_lvl;
    end else begin
      sin = sba_lvl;
    end
  end

  csio_shift_core u_core (
    .clock(clock),
    .rst_n(rst_n),
    .enable(serial_mode_reg_ff.en),
    .sck_level(sck_level),
    .sin(sin),
    .load(load),
    .load_data(wr_order),
    .set_latch(set_latch),
    .clr_latch(clr_latch),
    .stat(core)
  );

  // Wake-up select passes only transfers whose data matched the slave address
  assign done_ev = core.done & (~serial_mode_reg_ff.wake | addr_match);
  assign stat_rd = rd_fire & (s_axi_araddr == `CSIO_A_STAT);

  // done flag
  // A new event in the clearing read wins over the clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      transfer_done_flag_ff <= 1'b0;
    end else if (done_ev) begin
      transfer_done_flag_ff <= 1'b1;
    end else if (stat_rd) begin
      transfer_done_flag_ff <= 1'b0;
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rerr = 1'b0;
    case (s_axi_araddr)
      `CSIO_A_MODE: nxt_rdata[7:0] = serial_mode_reg_ff | ({7'h00, addr_match} << `CSIO_B_MATCH);
      `CSIO_A_DATA: nxt_rdata[7:0] = rd_order;
      `CSIO_A_BUSCTL: nxt_rdata[7:0] = 8'h00;
      `CSIO_A_STAT: nxt_rdata[`CSIO_B_DONE] = transfer_done_flag_ff;
      `CSIO_A_MASK: nxt_rdata[`CSIO_B_DONE] = mask_ff;
      `CSIO_A_BSET, `CSIO_A_BCLR: nxt_rdata[7:0] = 8'h00;
      `CSIO_A_SVA: nxt_rdata[7:0] = sva_ff;
      default: nxt_rerr = 1'b1;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `CSIO_RESP_OK;
    end else begin
      arready_ff <= s_axi_arvalid & ~arready_ff & ~rvalid_ff;
      if (rd_fire) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= nxt_rdata;
        rresp_ff <= nxt_rerr ? `CSIO_RESP_ERR : `CSIO_RESP_OK;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // Every pin except the tied-low data outputs is registered so no mux glitch reaches the board
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sck_out_ff <= 1'b1;
      sck_oe_ff <= 1'b0;
      so_ff <= `CSIO_LATCH_RST;
      sba_oe_ff <= 1'b0;
      sbb_oe_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      sck_out_ff <= sck_level;
      sck_oe_ff <= internal_clk;
      so_ff <= core.latch;
      sba_oe_ff <= two_wire & ~serial_mode_reg_ff.op[2] & ~core.latch;
      sbb_oe_ff <= two_wire & serial_mode_reg_ff.op[2] & ~core.latch;
      irq_ff <= transfer_done_flag_ff & mask_ff;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign irq = irq_ff;
  assign serial_clock_pin_out = sck_out_ff;
  assign serial_clock_pin_oe = sck_oe_ff;
  assign serial_out_latch = so_ff;
  assign bus_data_pin_a_out = 1'b0;
  assign bus_data_pin_b_out = 1'b0;
  assign bus_data_pin_a_oe = sba_oe_ff;
  assign bus_data_pin_b_oe = sbb_oe_ff;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_start_needs_en: assert property (load |-> serial_mode_reg_ff.en)
    else $error("transfer started while disabled");
  a_start_busy: assert property (load && serial_mode_reg_ff.en |=> core.busy)
    else $error("data write did not start transfer");
  a_late_enable: assert property (!core.busy && !load && $rose(serial_mode_reg_ff.en)
    |-> ##1 !core.busy)
    else $error("enable alone started a transfer");
  a_done_sets_flag: assert property (done_ev |=> transfer_done_flag_ff)
    else $error("done event lost");
  a_flag_irq: assert property (transfer_done_flag_ff && mask_ff |=> irq)
    else $error("irq not raised");
  a_mode_reset: assert property ($past(!rst_n) |-> serial_mode_reg_ff == 8'h00)
    else $error("mode not cleared by reset");
  a_match_unstored: assert property (!serial_mode_reg_ff.match)
    else $error("read-only bit stored");
  a_lsb_reorder: assert property (load && lsb_first |=> core.data[0] == $past(wbyte[7]))
    else $error("LSB-first reorder missing");
  a_sck_idle_high: assert property (internal_clk && clk_e[1] && !core.busy && !load
    ##1 !core.busy |-> sck_int_ff)
    else $error("internal clock not parked high");
  a_rel_sets_latch: assert property (set_latch |=> core.latch ##2 serial_out_latch)
    else $error("release trigger failed");
endmodule
`default_nettype wire

// [verification/csio_peer.sv]
// Far-side serial peer that clocks as master or follows as slave
`default_nettype none
module csio_peer (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sck_line,
  input wire logic sdo,
  input wire logic load,
  input wire logic go,
  input wire logic [7:0] tx_byte,
  input wire logic [3:0] half,
  output logic peer_sck,
  output logic sdi,
  output logic [7:0] rx_byte,
  output logic [3:0] nbits
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sck_q;
  logic [4:0] edges;
  logic [3:0] hcnt;
  logic [7:0] sh;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      peer_sck <= 1'b1;
      edges <= 5'h00;
      hcnt <= 4'h0;
    end else if (go) begin
      edges <= 5'h10;
      hcnt <= half;
    end else if (edges != 5'h00) begin
      if (hcnt == 4'h0) begin
        peer_sck <= ~peer_sck;
        edges <= edges - 5'h01;
        hcnt <= half;
      end else begin
        hcnt <= hcnt - 4'h1;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sck_q <= 1'b1;
      sdi <= 1'b0;
      sh <= 8'h00;
      rx_byte <= 8'h00;
      nbits <= 4'h0;
    end else begin
      sck_q <= sck_line;
      if (load) begin
        sh <= tx_byte;
        nbits <= 4'h0;
        sdi <= ~sdi;
      end else if (sck_q && !sck_line && nbits < 4'h8) begin
        sdi <= sh[7];
        sh <= {sh[6:0], 1'b0};
      end else if (!sck_q && sck_line) begin
        // Every rising edge is counted so a clock that never stops shows up
        nbits <= nbits + 4'h1;
        if (nbits < 4'h8) rx_byte <= {rx_byte[6:0], sdo};
        if (nbits == 4'h7) sdi <= ~sdi;
      end
    end
  end
endmodule
`default_nettype wire

// [verification/tb_clocked_serial_io_shifter.sv]
// Self-checking bench for the clocked serial shifter and its peer
`default_nettype none
`include "csio_cfg.svh"
module tb_clocked_serial_io_shifter;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] s_axi_awaddr = '0;
  logic [11:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, timer_out_in = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic serial_clock_pin_out, serial_clock_pin_oe, serial_out_latch, peer_sck, sdi;
  logic bus_data_pin_a_out, bus_data_pin_a_oe, bus_data_pin_b_out, bus_data_pin_b_oe;
  logic load = 1'b0, go = 1'b0;
  logic [7:0] tx_byte = '0, rx_byte;
  logic [3:0] half = 4'h6, nbits;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  wire logic serial_clock_pin_in = serial_clock_pin_oe ? serial_clock_pin_out : peer_sck;
  wire logic serial_in_pin = sdi;
  // Open-drain data pins rest high through the pull-up
  wire logic bus_data_pin_a_in = !(bus_data_pin_a_oe && !bus_data_pin_a_out);
  wire logic bus_data_pin_b_in = !(bus_data_pin_b_oe && !bus_data_pin_b_out);
  csio_top uut (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .irq, .timer_out_in, .serial_clock_pin_in, .serial_clock_pin_out,
    .serial_clock_pin_oe, .serial_out_latch, .serial_in_pin, .bus_data_pin_a_in,
    .bus_data_pin_a_out, .bus_data_pin_a_oe, .bus_data_pin_b_in, .bus_data_pin_b_out,
    .bus_data_pin_b_oe);
  csio_peer peer (.clock, .rst_n, .sck_line(serial_clock_pin_in), .sdo(serial_out_latch),
    .load, .go, .tx_byte, .half, .peer_sck, .sdi, .rx_byte, .nbits);
  always #2 clock = ~clock;
  // Timer source toggles every five cycles; the cycle ceiling cuts a hang short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc % 5 == 0) timer_out_in <= ~timer_out_in;
    if (cyc == 30000) begin
      n_errors++;
      results();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic wr_ok(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    check("bresp", 32'(r), 32'(`CSIO_RESP_OK));
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m,
                        input string what);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    check(what, s_axi_rdata & m, exp);
    check("rresp", 32'(s_axi_rresp), 32'(`CSIO_RESP_OK));
    s_axi_rready <= 1'b0;
  endtask
  task automatic peer_load(input logic [7:0] b);
    @(posedge clock);
    tx_byte <= b;
    load <= 1'b1;
    @(posedge clock);
    load <= 1'b0;
  endtask
  task automatic peer_clk();
    @(posedge clock);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    while (nbits < 4'h8) @(posedge clock);
  endtask
  task automatic t_regs();
    logic [1:0] r;
    // Match bit reads live: a cleared shift register equals the cleared slave address
    rd_chk(`CSIO_A_MODE, 32'h40, 32'hFF, "mode reset");
    check("latch reset", 32'(serial_out_latch), 32'h1);
    wr_ok(`CSIO_A_MODE, 32'h9F);
    rd_chk(`CSIO_A_MODE, 32'h9F, 32'hBF, "mode layout");
    check("sck oe int", 32'(serial_clock_pin_oe), 32'h1);
    wr_ok(`CSIO_A_MODE, 32'h84);
    rd_chk(`CSIO_A_MODE, 32'h84, 32'hBF, "mode 84");
    check("sck oe ext", 32'(serial_clock_pin_oe), 32'h0);
    wr_ok(`CSIO_A_BSET, 32'hA0);
    rd_chk(`CSIO_A_MODE, 32'hA4, 32'hBF, "bit set");
    wr_ok(`CSIO_A_BCLR, 32'hA0);
    rd_chk(`CSIO_A_MODE, 32'h04, 32'hBF, "bit clear");
    wr(12'h000, 32'h1, r);
    check("unmapped", 32'(r), 32'(`CSIO_RESP_ERR));
    $display("test registers done");
  endtask
  task automatic t_trig();
    wr_ok(`CSIO_A_MODE, 32'h8C);
    wr_ok(`CSIO_A_BUSCTL, 32'h1);
    repeat (2) @(posedge clock);
    check("cmd latch", 32'(serial_out_latch), 32'h0);
    check("pin a pull", 32'(bus_data_pin_a_oe), 32'h1);
    check("pin b idle", 32'(bus_data_pin_b_oe), 32'h0);
    wr_ok(`CSIO_A_BUSCTL, 32'h2);
    repeat (2) @(posedge clock);
    check("rel latch", 32'(serial_out_latch), 32'h1);
    check("pin a rel", 32'(bus_data_pin_a_oe), 32'h0);
    rd_chk(`CSIO_A_BUSCTL, 32'h0, 32'h3, "trig clear");
    $display("test triggers done");
  endtask
  // Internal clock sources; a back-to-back call is the exchange access
  task automatic t_int(input logic [7:0] m, input logic [7:0] tx, input logic [7:0] ptx);
    wr_ok(`CSIO_A_MODE, 32'(m));
    peer_load(ptx);
    wr_ok(`CSIO_A_DATA, 32'(tx));
    while (irq !== 1'b1) @(posedge clock);
    check("peer rx", 32'(rx_byte), 32'(tx));
    check("sck park", 32'(serial_clock_pin_out), 32'h1);
    rd_chk(`CSIO_A_DATA, 32'(ptx), 32'hFF, "rx data");
    rd_chk(`CSIO_A_STAT, 32'h1, 32'h1, "done set");
    rd_chk(`CSIO_A_STAT, 32'h0, 32'h1, "done read clr");
    check("eight clocks", 32'(nbits), 32'h8);
    check("irq clear", 32'(irq), 32'h0);
    $display("test transfer mode %h done", m);
  endtask
  // Wake-up select: only a byte equal to the slave address raises the done flag
  task automatic t_wake();
    wr_ok(`CSIO_A_SVA, 32'h5C);
    wr_ok(`CSIO_A_MODE, 32'hA3);
    peer_load(8'h11);
    wr_ok(`CSIO_A_DATA, 32'h00);
    while (nbits < 4'h8) @(posedge clock);
    repeat (4) @(posedge clock);
    rd_chk(`CSIO_A_STAT, 32'h0, 32'h1, "wake miss");
    peer_load(8'h5C);
    wr_ok(`CSIO_A_DATA, 32'h00);
    while (irq !== 1'b1) @(posedge clock);
    rd_chk(`CSIO_A_MODE, 32'hE3, 32'hFF, "match bit");
    rd_chk(`CSIO_A_STAT, 32'h1, 32'h1, "wake hit");
    $display("test wake done");
  endtask
  task automatic t_lsb_ext();
    // order before data
    // Enable stays off here so the data write is refused and the late enable is tested
    wr_ok(`CSIO_A_MODE, 32'h04);
    peer_load(8'h35);
    wr_ok(`CSIO_A_DATA, 32'h12);
    wr_ok(`CSIO_A_BSET, 32'h80);
    peer_clk();
    repeat (20) @(posedge clock);
    check("late enable", 32'(irq), 32'h0);
    peer_load(8'h35);
    wr_ok(`CSIO_A_DATA, 32'h12);
    peer_clk();
    while (irq !== 1'b1) @(posedge clock);
    check("peer rx lsb", 32'(rx_byte), 32'(rev(8'h12)));
    rd_chk(`CSIO_A_DATA, 32'(rev(8'h35)), 32'hFF, "rx lsb");
    rd_chk(`CSIO_A_STAT, 32'h1, 32'h1, "ext done");
    $display("test external lsb done");
  endtask
  task automatic t_abort();
    wr_ok(`CSIO_A_MODE, 32'h82);
    peer_load(8'hFF);
    wr_ok(`CSIO_A_DATA, 32'h3C);
    repeat (40) @(posedge clock);
    wr_ok(`CSIO_A_BCLR, 32'h80);
    repeat (300) @(posedge clock);
    check("abort irq", 32'(irq), 32'h0);
    check("abort bits", 32'(nbits < 4'h8), 32'h1);
    rd_chk(`CSIO_A_STAT, 32'h0, 32'h1, "abort done");
    wr_ok(`CSIO_A_MASK, 32'h0);
    wr_ok(`CSIO_A_BSET, 32'h80);
    peer_load(8'h66);
    wr_ok(`CSIO_A_DATA, 32'h99);
    while (nbits < 4'h8) @(posedge clock);
    repeat (2) @(posedge clock);
    check("masked irq", 32'(irq), 32'h0);
    wr_ok(`CSIO_A_MASK, 32'h1);
    repeat (2) @(posedge clock);
    check("unmasked irq", 32'(irq), 32'h1);
    rd_chk(`CSIO_A_STAT, 32'h1, 32'h1, "done kept");
    repeat (2) @(posedge clock);
    check("irq cleared", 32'(irq), 32'h0);
    $display("test abort and mask done");
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_trig();
    wr_ok(`CSIO_A_MASK, 32'h1);
    t_int(8'h83, 8'hA5, 8'h3C);
    t_int(8'h83, 8'h5A, 8'hC1);
    t_int(8'h82, 8'h96, 8'h0F);
    t_int(8'h81, 8'h01, 8'h80);
    t_wake();
    t_lsb_ext();
    t_abort();
    results();
  end
endmodule
`default_nettype wire
